// File: rtl/status_word_pkg.sv
// constants for the program status word block
package status_word_pkg;
    localparam logic [7:0] STATUS_WORD_OFS = 8'hD0;
    localparam logic [7:0] STATUS_WORD_RST = 8'h00;
    localparam int CARRY_BIT = 7;
    localparam int HALF_BIT = 6;
    localparam int USER0_BIT = 5;
    localparam int BANK_HI_BIT = 4;
    localparam int BANK_LO_BIT = 3;
    localparam int WRAP_BIT = 2;
    localparam int USER1_BIT = 1;
    localparam int PARITY_BIT = 0;
    localparam logic [15:0] PRODUCT_LIMIT = 16'h00FF;
    localparam logic [8:0] BCD_LIMIT = 9'h099;
    localparam logic [4:0] BANK_STRIDE = 5'h08;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD = 4'h1,
        OP_ADD_CARRY = 4'h2,
        OP_SUB_BORROW = 4'h3,
        OP_PRODUCT = 4'h4,
        OP_QUOTIENT = 4'h5,
        OP_DEC_ADJUST = 4'h6,
        OP_COMPARE_JUMP = 4'h7,
        OP_CARRY_HIGH = 4'h8,
        OP_CARRY_LOW = 4'h9,
        OP_CARRY_LOAD = 4'hA
    } flag_op_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;
endpackage : status_word_pkg

// File: rtl/program_status_flags.sv
// program status word: arithmetic flags, user flags, bank select, parity
// Functional notes
// - add/subtract: carry flag is carry out of or borrow into bit 7
// - product and quotient always clear the carry flag
// - decimal adjust sets carry when the packed BCD sum exceeds two digits
// - compare-and-jump sets carry when operand a is below operand b
// - half carry is carry out of or borrow into bit 3
// - user flags at bits 5 and 1 are plain software storage
// - bank select picks RAM window 00-07, 08-0F, 10-17 or 18-1F
// - add forms: signed wrap is carry out of bit 6 xor bit 7
// - subtract with borrow: signed wrap is borrow into bit 6 xor bit 7
// - product: signed wrap set when product exceeds 00FFH
// - quotient: signed wrap cleared, set on a zero divisor
// - parity bit is one for an odd count of accumulator ones
// - bit ops force, clear or load the carry flag from their result
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module program_status_flags (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // execution datapath
    input wire status_word_pkg::flag_op_t i_op,
    input wire logic [7:0] i_opa,
    input wire logic [7:0] i_opb,
    input wire logic i_bit_value,
    input wire logic [7:0] i_acc,
    // flag outputs
    output logic o_carry_flag,
    output logic o_half_carry_flag,
    output logic o_signed_wrap_flag,
    output logic o_odd_ones_indicator,
    output logic [4:0] o_bank_base
);
    import status_word_pkg::*;

    default clocking cb_main @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    logic [7:0] status_q;
    logic parity_q;
    bus_state_t bus_q;
    logic [31:0] rdata_q;

    // arithmetic helpers
    logic cin;
    logic [8:0] sum9;
    logic [7:0] sum7;
    logic [4:0] sum4;
    logic [8:0] dif9;
    logic [7:0] dif7;
    logic [4:0] dif4;
    logic [15:0] product;
    logic [8:0] bcd_sum;
    logic [3:0] low_adj;

    assign cin = (i_op == OP_ADD) ? 1'b0 : status_q[CARRY_BIT];
    assign sum9 = {1'b0, i_opa} + {1'b0, i_opb} + {8'h00, cin};
    assign sum7 = {1'b0, i_opa[6:0]} + {1'b0, i_opb[6:0]} + {7'h00, cin};
    assign sum4 = {1'b0, i_opa[3:0]} + {1'b0, i_opb[3:0]} + {4'h0, cin};
    assign dif9 = {1'b0, i_opa} - {1'b0, i_opb} - {8'h00, cin};
    assign dif7 = {1'b0, i_opa[6:0]} - {1'b0, i_opb[6:0]} - {7'h00, cin};
    assign dif4 = {1'b0, i_opa[3:0]} - {1'b0, i_opb[3:0]} - {4'h0, cin};
    assign product = i_opa * i_opb;
    // decimal adjust sees the accumulator on i_opa after the add
    assign low_adj = (i_opa[3:0] > 4'h9 || status_q[HALF_BIT]) ? 4'h6 : 4'h0;
    assign bcd_sum = {1'b0, i_opa} + {5'h00, low_adj};

    logic wr_hit;
    assign wr_hit = (bus_q == BUS_IDLE) && i_avs_write
        && i_avs_byteenable[0] && (i_avs_address == STATUS_WORD_OFS);

    // flag update; a software write wins over an instruction in that cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            status_q <= STATUS_WORD_RST;
        end else if (wr_hit) begin
            status_q[7:1] <= i_avs_writedata[7:1];
        end else begin
            case (i_op)
                OP_ADD, OP_ADD_CARRY: begin
                    status_q[CARRY_BIT] <= sum9[8];
                    status_q[HALF_BIT] <= sum4[4];
                    status_q[WRAP_BIT] <= sum9[8] ^ sum7[7];
                end
                OP_SUB_BORROW: begin
                    status_q[CARRY_BIT] <= dif9[8];
                    status_q[HALF_BIT] <= dif4[4];
                    status_q[WRAP_BIT] <= dif9[8] ^ dif7[7];
                end
                OP_PRODUCT: begin
                    status_q[CARRY_BIT] <= 1'b0;
                    status_q[WRAP_BIT] <= product > PRODUCT_LIMIT;
                end
                OP_QUOTIENT: begin
                    status_q[CARRY_BIT] <= 1'b0;
                    status_q[WRAP_BIT] <= (i_opb == 8'h00);
                end
                OP_DEC_ADJUST: begin
                    status_q[CARRY_BIT] <= status_q[CARRY_BIT]
                        || (bcd_sum > BCD_LIMIT);
                end
                OP_COMPARE_JUMP: begin
                    status_q[CARRY_BIT] <= (i_opa < i_opb);
                end
                OP_CARRY_HIGH: status_q[CARRY_BIT] <= 1'b1;
                OP_CARRY_LOW: status_q[CARRY_BIT] <= 1'b0;
                OP_CARRY_LOAD: status_q[CARRY_BIT] <= i_bit_value;
                default: status_q <= status_q;
            endcase
        end
    end

    // parity follows the accumulator, never the bus
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            parity_q <= 1'b0;
        end else begin
            parity_q <= ^i_acc;
        end
    end

    // one wait cycle per access, then acknowledge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_q <= BUS_IDLE;
        end else begin
            case (bus_q)
                BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_q <= BUS_ACK;
                    end
                end
                BUS_ACK: bus_q <= BUS_IDLE;
                default: bus_q <= BUS_IDLE;
            endcase
        end
    end

    // unmapped addresses read zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_q == BUS_IDLE && i_avs_read) begin
            if (i_avs_address == STATUS_WORD_OFS) begin
                rdata_q <= {24'h00_0000, status_q[7:1], parity_q};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    assign o_avs_waitrequest = (i_avs_read || i_avs_write)
        && (bus_q != BUS_ACK);
    assign o_avs_readdata = rdata_q;
    assign o_carry_flag = status_q[CARRY_BIT];
    assign o_half_carry_flag = status_q[HALF_BIT];
    assign o_signed_wrap_flag = status_q[WRAP_BIT];
    assign o_odd_ones_indicator = parity_q;
    assign o_bank_base = 5'({status_q[BANK_HI_BIT], status_q[BANK_LO_BIT]})
        * BANK_STRIDE;

    // reference values built apart from the datapath adders above
    logic [7:0] ref_sum;
    logic [7:0] ref_dif;
    logic ref_add_carry;
    logic ref_add_half;
    logic ref_add_wrap;
    logic ref_sub_borrow;
    logic ref_sub_half;
    logic ref_sub_wrap;

    assign ref_sum = i_opa + i_opb + {7'h00, cin};
    assign ref_dif = i_opa - i_opb - {7'h00, cin};
    // a wrapped sum is below operand a, or equal to it with carry in
    assign ref_add_carry = (ref_sum < i_opa) || ((ref_sum == i_opa) && cin);
    assign ref_add_half = (ref_sum[3:0] < i_opa[3:0])
        || ((ref_sum[3:0] == i_opa[3:0]) && cin);
    // signed wrap: like-signed operands, result of the other sign
    assign ref_add_wrap = (i_opa[7] == i_opb[7]) && (ref_sum[7] != i_opa[7]);
    assign ref_sub_borrow = ({1'b0, i_opb} + {8'h00, cin}) > {1'b0, i_opa};
    assign ref_sub_half = ({1'b0, i_opb[3:0]} + {4'h0, cin})
        > {1'b0, i_opa[3:0]};
    // subtract wraps when the signs differ and the result leaves a's sign
    assign ref_sub_wrap = (i_opa[7] != i_opb[7]) && (ref_dif[7] != i_opa[7]);

    sequence s_add_op;
        (i_op == OP_ADD) && !wr_hit;
    endsequence
    sequence s_add_any;
        (i_op inside {OP_ADD, OP_ADD_CARRY}) && !wr_hit;
    endsequence
    sequence s_sub_op;
        (i_op == OP_SUB_BORROW) && !wr_hit;
    endsequence
    sequence s_idle_op;
        (i_op == OP_NONE) && !wr_hit;
    endsequence
    sequence s_bus_take;
        (bus_q == BUS_IDLE) && (i_avs_read || i_avs_write);
    endsequence

    // add and subtract-with-borrow flags
    chk_add_carry_out: assert property (
        s_add_any |=> o_carry_flag == $past(ref_add_carry))
        else $error("add carry wrong");

    chk_half_carry_add: assert property (
        s_add_any |=> o_half_carry_flag == $past(ref_add_half))
        else $error("half carry wrong");

    chk_add_wrap: assert property (
        s_add_any |=> o_signed_wrap_flag == $past(ref_add_wrap))
        else $error("add signed wrap wrong");

    chk_sub_borrow: assert property (
        s_sub_op |=> o_carry_flag == $past(ref_sub_borrow))
        else $error("subtract borrow wrong");

    chk_sub_half: assert property (
        s_sub_op |=> o_half_carry_flag == $past(ref_sub_half))
        else $error("subtract half borrow wrong");

    chk_sub_wrap: assert property (
        s_sub_op |=> o_signed_wrap_flag == $past(ref_sub_wrap))
        else $error("subtract signed wrap wrong");

    // product, quotient, compare and decimal adjust
    chk_mul_div_carry: assert property (
        (i_op inside {OP_PRODUCT, OP_QUOTIENT}) && !wr_hit
        |=> !o_carry_flag)
        else $error("carry not cleared by product or quotient");

    chk_compare_carry: assert property (
        (i_op == OP_COMPARE_JUMP) && !wr_hit
        |=> o_carry_flag == $past(i_opa < i_opb))
        else $error("compare carry wrong");

    chk_product_wrap: assert property (
        (i_op == OP_PRODUCT) && !wr_hit |=> o_signed_wrap_flag
            == ($past(16'(i_opa) * 16'(i_opb)) > PRODUCT_LIMIT))
        else $error("product wrap wrong");

    chk_zero_divisor: assert property (
        (i_op == OP_QUOTIENT) && !wr_hit
        |=> o_signed_wrap_flag == ($past(i_opb) == 8'h00))
        else $error("quotient wrap wrong");

    chk_da_carry_keep: assert property (
        (i_op == OP_DEC_ADJUST) && !wr_hit && o_carry_flag
        |=> o_carry_flag)
        else $error("decimal adjust dropped the carry");

    chk_da_carry_high: assert property (
        (i_op == OP_DEC_ADJUST) && !wr_hit && (i_opa[7:4] > 4'h9)
        |=> o_carry_flag)
        else $error("decimal adjust missed the hundreds carry");

    chk_da_only_carry: assert property (
        (i_op == OP_DEC_ADJUST) && !wr_hit
        |=> $stable(o_half_carry_flag) && $stable(o_signed_wrap_flag))
        else $error("decimal adjust touched other flags");

    // bit operations on the carry
    chk_carry_force: assert property (
        (i_op == OP_CARRY_HIGH) && !wr_hit ##1 s_idle_op
        |=> o_carry_flag)
        else $error("carry force lost");

    chk_carry_low: assert property (
        (i_op == OP_CARRY_LOW) && !wr_hit |=> !o_carry_flag)
        else $error("carry clear failed");

    chk_carry_load: assert property (
        (i_op == OP_CARRY_LOAD) && !wr_hit |=> o_carry_flag == $past(i_bit_value))
        else $error("carry load wrong");

    chk_bit_ops_only: assert property (
        (i_op inside {OP_CARRY_HIGH, OP_CARRY_LOW, OP_CARRY_LOAD}) && !wr_hit
        |=> $stable(o_half_carry_flag) && $stable(o_signed_wrap_flag))
        else $error("bit operation touched other flags");

    // parity, bank and user storage
    chk_parity_tracks: assert property (
        ##1 o_odd_ones_indicator == ^$past(i_acc))
        else $error("parity wrong");

    chk_bank_window: assert property (
        o_bank_base
            == {status_q[BANK_HI_BIT], status_q[BANK_LO_BIT], 3'h0})
        else $error("bank base misaligned");

    chk_bank_hold: assert property (
        !wr_hit |=> $stable(o_bank_base))
        else $error("bank base moved without a write");

    chk_user_hold: assert property (
        !wr_hit
        |=> $stable(status_q[USER0_BIT]) && $stable(status_q[USER1_BIT]))
        else $error("user flag moved without a write");

    // software access and the bus handshake
    chk_write_stores: assert property (
        wr_hit ##1 s_idle_op |=> o_half_carry_flag == $past(i_avs_writedata[6], 2))
        else $error("written flag not stored");

    chk_idle_keeps: assert property (
        s_idle_op |=> $stable(status_q[7:1]))
        else $error("status word moved while idle");

    chk_write_refused: assert property (
        i_avs_write && (i_op == OP_NONE)
        && (!i_avs_byteenable[0] || (i_avs_address != STATUS_WORD_OFS))
        |=> $stable(status_q[7:1]))
        else $error("refused write changed the status word");

    chk_wait_first: assert property (
        s_bus_take |-> o_avs_waitrequest)
        else $error("request answered without a wait cycle");

    chk_wait_once: assert property (
        s_bus_take |=> !o_avs_waitrequest)
        else $error("request not answered after one wait cycle");

    chk_unmapped_read: assert property (
        (bus_q == BUS_IDLE) && i_avs_read && (i_avs_address != STATUS_WORD_OFS)
        |=> o_avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_read_upper: assert property (
        (bus_q == BUS_IDLE) && i_avs_read
        |=> o_avs_readdata[31:8] == 24'h00_0000)
        else $error("upper read lanes not zero");
endmodule : program_status_flags

// File: dv/exec_datapath_model.sv
// datapath stand-in that issues one flag operation at a time
`timescale 1ns/1ps
module exec_datapath_model (
    // clock
    input wire logic i_clk,
    // datapath drive
    output status_word_pkg::flag_op_t o_op,
    output logic [7:0] o_opa,
    output logic [7:0] o_opb,
    output logic o_bit_value,
    output logic [7:0] o_acc
);
    import status_word_pkg::*;
    initial begin
        o_op = OP_NONE;
        o_opa = 8'h00;
        o_opb = 8'h00;
        o_bit_value = 1'b0;
        o_acc = 8'h00;
    end
    // the accumulator follows operand a, so parity tracks each operation
    task issue(input flag_op_t op, input logic [7:0] a, input logic [7:0] b,
               input logic bv);
        @(posedge i_clk);
        o_op <= op;
        o_opa <= a;
        o_opb <= b;
        o_bit_value <= bv;
        o_acc <= a;
        @(posedge i_clk);
        o_op <= OP_NONE;
        @(posedge i_clk);
    endtask : issue
endmodule : exec_datapath_model

// File: dv/testbench.sv
// self-checking bench for the program status word block
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    $display("unexpected %s exp %h got %h", n, e, s); failures++; end end
module testbench;
    import status_word_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] ben = 4'h0;
    logic [31:0] rdat, q;
    logic wait_req, bitv, cy, hc, ov, par;
    flag_op_t op;
    logic [7:0] opa, opb, acc;
    logic [4:0] bank;
    int failures = 0;
    int total_checks = 0;
    always #12.5 i_clk = ~i_clk;
    program_status_flags program_status_flags_inst (.i_clk(i_clk),
        .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(ben),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_req), .i_op(op),
        .i_opa(opa), .i_opb(opb), .i_bit_value(bitv), .i_acc(acc),
        .o_carry_flag(cy), .o_half_carry_flag(hc), .o_signed_wrap_flag(ov),
        .o_odd_ones_indicator(par), .o_bank_base(bank));
    exec_datapath_model exec_datapath_model_inst (.i_clk(i_clk), .o_op(op),
        .o_opa(opa), .o_opb(opb), .o_bit_value(bitv), .o_acc(acc));
    task conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // request held until waitrequest is seen low at a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic [3:0] be);
        int n;
        @(posedge i_clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        ben <= be;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (wait_req === 1'b0) break;
        end
        if (n == 20) begin
            $display("unexpected waitrequest exp 0 got 1");
            failures++;
            conclude();
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task run(input flag_op_t o, input logic [7:0] a, input logic [7:0] b,
             input logic bv, input logic [2:0] e);
        exec_datapath_model_inst.issue(o, a, b, bv);
        `CHK("flags", {e, ^a}, {cy, hc, ov, par})
    endtask : run
    task test_regs;
        bus(1'b0, 8'hD0, 8'h00, 4'h1);
        `CHK("reset", 32'h0, q)
        bus(1'b1, 8'hD0, 8'hFF, 4'h1);
        bus(1'b0, 8'hD0, 8'h00, 4'h1);
        `CHK("parity_wr", 32'hFE, q)
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'hD0, 8'(k * 8), 4'h1);
            `CHK("bank", 5'(k * 8), bank)
        end
        bus(1'b1, 8'hD0, 8'h00, 4'h0);
        bus(1'b0, 8'hD0, 8'h00, 4'h1);
        `CHK("no_lane", 32'h18, q)
        bus(1'b0, 8'hD1, 8'h00, 4'h1);
        `CHK("unmapped", 32'h0, q)
        bus(1'b1, 8'hD0, 8'h22, 4'h1);
        $display("test regs done");
    endtask : test_regs
    task test_arith;
        run(OP_ADD, 8'h7F, 8'h01, 1'b0, 3'b011);
        run(OP_ADD, 8'hFF, 8'h01, 1'b0, 3'b110);
        run(OP_ADD_CARRY, 8'h7F, 8'h00, 1'b0, 3'b011);
        run(OP_SUB_BORROW, 8'h80, 8'h01, 1'b0, 3'b011);
        run(OP_SUB_BORROW, 8'h00, 8'h01, 1'b0, 3'b110);
        $display("test arith done");
    endtask : test_arith
    task test_muldiv;
        run(OP_PRODUCT, 8'h10, 8'h10, 1'b0, 3'b011);
        run(OP_PRODUCT, 8'h0F, 8'h11, 1'b0, 3'b010);
        run(OP_CARRY_HIGH, 8'h00, 8'h00, 1'b0, 3'b110);
        run(OP_QUOTIENT, 8'h07, 8'h00, 1'b0, 3'b011);
        run(OP_QUOTIENT, 8'h07, 8'h02, 1'b0, 3'b010);
        $display("test muldiv done");
    endtask : test_muldiv
    task test_carry;
        run(OP_COMPARE_JUMP, 8'h03, 8'h05, 1'b0, 3'b110);
        run(OP_COMPARE_JUMP, 8'h05, 8'h03, 1'b0, 3'b010);
        run(OP_CARRY_LOAD, 8'h01, 8'h00, 1'b1, 3'b110);
        run(OP_CARRY_LOW, 8'h00, 8'h00, 1'b0, 3'b010);
        run(OP_DEC_ADJUST, 8'h9A, 8'h00, 1'b0, 3'b110);
        run(OP_DEC_ADJUST, 8'h12, 8'h00, 1'b0, 3'b110);
        run(OP_CARRY_LOAD, 8'h00, 8'h00, 1'b0, 3'b010);
        run(OP_DEC_ADJUST, 8'h45, 8'h00, 1'b0, 3'b010);
        run(OP_DEC_ADJUST, 8'hA3, 8'h00, 1'b0, 3'b110);
        bus(1'b0, 8'hD0, 8'h00, 4'h1);
        `CHK("user", 8'h22, q[7:0] & 8'h22)
        $display("test carry done");
    endtask : test_carry
    // reset in mid-run; the accumulator still holds A3h, even parity
    task test_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        `CHK("rst_flags", 3'b000, {cy, hc, ov})
        bus(1'b0, 8'hD0, 8'h00, 4'h1);
        `CHK("rst_word", 32'h00, q)
        $display("test reset done");
    endtask : test_reset
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        test_regs();
        test_arith();
        test_muldiv();
        test_carry();
        test_reset();
        conclude();
    end
endmodule : testbench
